// >>> rtl/arns_defines.vh
// constants for the native-max and read-sector command block
`ifndef ARNS_DEFINES_VH
`define ARNS_DEFINES_VH

// apb word offsets of the task-file registers
`define ARNS_OFF_DATA      8'h00
`define ARNS_OFF_ERR       8'h04
`define ARNS_OFF_SCNT      8'h08
`define ARNS_OFF_SNUM      8'h0c
`define ARNS_OFF_CYLL      8'h10
`define ARNS_OFF_CYLH      8'h14
`define ARNS_OFF_DEVHD     8'h18
`define ARNS_OFF_CMDSTAT   8'h1c
`define ARNS_OFF_DEVCTL    8'h20

// command codes
`define ARNS_CMD_NMAX      8'hf8
`define ARNS_CMD_NMAX_EXT  8'h27
`define ARNS_CMD_READ      8'h20

// device/head fields
`define ARNS_DH_LBA        6
`define ARNS_DH_DEV        4
// device control field
`define ARNS_DC_HOB        7

// error register bits
`define ARNS_ERR_UNC       6
`define ARNS_ERR_IDNF      4
`define ARNS_ERR_ABRT      2

// status register bits
`define ARNS_ST_BSY        7
`define ARNS_ST_RDY        6
`define ARNS_ST_DSC        4
`define ARNS_ST_DRQ        3
`define ARNS_ST_ERR        0

// largest address the 28-bit form can carry
`define ARNS_MAX28         28'hfffffff
// zero sector count means this many sectors
`define ARNS_FULL_COUNT    9'h100

`endif

// >>> rtl/arns_sector_buf.v
// one-sector word buffer with registered read data
`timescale 1ns/10ps
module arns_sector_buf #(
    parameter DW = 16,
    parameter AW = 8
) (
    input  wire          ref_clk,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // arns_sector_buf

// >>> rtl/arns_cmd.v
// task-file command engine: native max address and read sectors
// Behaviour
// - command f8h reports native max address, LBA or CHS, ignoring set-max limits
// - f8h clamps a native max above 268,435,455 to 268,435,455
// - f8h in LBA mode puts bits 7:0, 15:8, 23:16 in sector, cyl low, cyl high
// - f8h in LBA mode puts bits 27:24 in the head field
// - f8h in CHS mode returns max sector, cylinder and head numbers
// - command 27h reports the full 48-bit native max LBA
// - 27h with high byte select 0 reads LBA bits 7:0, 15:8, 23:16
// - 27h with high byte select 1 reads LBA bits 31:24, 39:32, 47:40
// - commands 20h/21h read each sector from media, then hand it over before the next
// - sector data leaves the data register as successive 16-bit words
// - an uncorrectable sector stops the transfer at that sector
// - sector count gives the run length; zero means 256 sectors
// - the low command bit is a retry flag and is ignored
// - after a read, sector count holds sectors not transferred
// - after a read, address registers hold the last transferred sector; on an uncorrectable error they hold the failing sector
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "arns_defines.vh"
module arns_cmd #(
    parameter WPS_LOG2 = 8
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [47:0] native_max_lba,
    input  wire [15:0] native_max_cyl,
    input  wire [3:0]  native_max_head,
    input  wire [7:0]  native_max_sector,
    input  wire [3:0]  geo_heads,
    input  wire [7:0]  geo_sectors,
    output wire        media_req,
    output wire        media_lba_mode,
    output wire [27:0] media_addr,
    input  wire        media_valid,
    input  wire [15:0] media_data,
    output wire        media_ready,
    input  wire        media_uncorr
);
    localparam ST_IDLE = 2'd0;
    localparam ST_REQ  = 2'd1;
    localparam ST_FILL = 2'd2;
    localparam ST_XFER = 2'd3;
    localparam [WPS_LOG2-1:0] LAST_WORD = {WPS_LOG2{1'b1}};
    localparam [7:0]          CMD_READ  = `ARNS_CMD_READ;

    reg [1:0]          state_q;
    reg [7:0]          err_q;
    reg                errst_q;
    reg [8:0]          rem_q;
    reg [7:0]          sec_q;
    reg [7:0]          cyll_q;
    reg [7:0]          cylh_q;
    reg [3:0]          head_q;
    reg                lba_q;
    reg                dev_q;
    reg [7:0]          hsec_q;
    reg [7:0]          hcyll_q;
    reg [7:0]          hcylh_q;
    reg                hob_q;
    reg [WPS_LOG2-1:0] wptr_q;
    reg [WPS_LOG2-1:0] rptr_q;
    reg [WPS_LOG2-1:0] rptr_d;

    wire [15:0] buf_rdata;
    wire        setup_rd = psel & ~penable & ~pwrite;
    wire        acc      = psel & penable;
    wire        wr_acc   = acc & pwrite & ~pslverr;
    wire        rd_acc   = acc & ~pwrite & ~pslverr;
    wire        idle     = (state_q == ST_IDLE);
    wire [7:0]  off      = paddr;
    wire [27:0] cur_lba  = {head_q, cylh_q, cyll_q, sec_q};
    wire        fill_beat = media_valid & media_ready;
    wire        pop = rd_acc & (off == `ARNS_OFF_DATA) & (state_q == ST_XFER);
    wire [27:0] max28;

    // unmapped or unaligned word offsets answer with an error
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `ARNS_OFF_DEVCTL);
        end
    endfunction

    assign pready      = 1'b1;
    assign pslverr     = acc & ~mapped(off);
    assign media_req   = (state_q == ST_REQ);
    assign media_ready = (state_q == ST_FILL);
    assign media_lba_mode = lba_q;
    assign media_addr  = cur_lba;
    // the 28-bit form cannot carry more, so it saturates
    assign max28 = (native_max_lba > {20'h00000, `ARNS_MAX28}) ?
                   `ARNS_MAX28 : native_max_lba[27:0];

    // read address looks one word ahead so data is ready by the next setup
    always @* begin
        rptr_d = rptr_q;
        if (pop) begin
            rptr_d = rptr_q + 1'b1;
        end
    end

    arns_sector_buf #(
        .DW (16),
        .AW (WPS_LOG2)
    ) u_buf (
        .ref_clk (ref_clk),
        .wr_en   (fill_beat),
        .wr_addr (wptr_q),
        .wr_data (media_data),
        .rd_addr (rptr_d),
        .rd_data (buf_rdata)
    );

    // read data is captured in the setup cycle, so no wait states are needed
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (setup_rd) begin
            prdata <= 32'h00000000;
            case (off)
                `ARNS_OFF_DATA: begin
                    if (state_q == ST_XFER) begin
                        prdata <= {16'h0000, buf_rdata};
                    end
                end
                `ARNS_OFF_ERR:  prdata <= {24'h000000, err_q};
                `ARNS_OFF_SCNT: prdata <= {24'h000000, rem_q[7:0]};
                `ARNS_OFF_SNUM: prdata <= {24'h000000, hob_q ? hsec_q : sec_q};
                `ARNS_OFF_CYLL: prdata <= {24'h000000, hob_q ? hcyll_q : cyll_q};
                `ARNS_OFF_CYLH: prdata <= {24'h000000, hob_q ? hcylh_q : cylh_q};
                `ARNS_OFF_DEVHD: prdata <= {24'h000000, 1'b1, lba_q, 1'b1, dev_q, head_q};
                `ARNS_OFF_CMDSTAT: begin
                    prdata[`ARNS_ST_BSY] <= ~idle & (state_q != ST_XFER);
                    prdata[`ARNS_ST_RDY] <= 1'b1;
                    prdata[`ARNS_ST_DSC] <= 1'b1;
                    prdata[`ARNS_ST_DRQ] <= (state_q == ST_XFER);
                    prdata[`ARNS_ST_ERR] <= errst_q;
                end
                `ARNS_OFF_DEVCTL: prdata[`ARNS_DC_HOB] <= hob_q;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            err_q   <= 8'h00;
            errst_q <= 1'b0;
            rem_q   <= 9'h000;
            sec_q   <= 8'h00;
            cyll_q  <= 8'h00;
            cylh_q  <= 8'h00;
            head_q  <= 4'h0;
            lba_q   <= 1'b0;
            dev_q   <= 1'b0;
            hsec_q  <= 8'h00;
            hcyll_q <= 8'h00;
            hcylh_q <= 8'h00;
            hob_q   <= 1'b0;
            wptr_q  <= {WPS_LOG2{1'b0}};
            rptr_q  <= {WPS_LOG2{1'b0}};
        end else begin
            rptr_q <= rptr_d;
            // device control stays writable while busy so a reader can flip pages
            if (wr_acc && off == `ARNS_OFF_DEVCTL) begin
                hob_q <= pwdata[`ARNS_DC_HOB];
            end
            // task-file writes other than device control only land while no command runs
            if (wr_acc && idle) begin
                case (off)
                    `ARNS_OFF_SCNT: rem_q <= {1'b0, pwdata[7:0]};
                    `ARNS_OFF_SNUM: begin
                        hsec_q <= sec_q;
                        sec_q  <= pwdata[7:0];
                    end
                    `ARNS_OFF_CYLL: begin
                        hcyll_q <= cyll_q;
                        cyll_q  <= pwdata[7:0];
                    end
                    `ARNS_OFF_CYLH: begin
                        hcylh_q <= cylh_q;
                        cylh_q  <= pwdata[7:0];
                    end
                    `ARNS_OFF_DEVHD: begin
                        head_q <= pwdata[3:0];
                        lba_q  <= pwdata[`ARNS_DH_LBA];
                        dev_q  <= pwdata[`ARNS_DH_DEV];
                    end
                    `ARNS_OFF_CMDSTAT: begin
                        err_q   <= 8'h00;
                        errst_q <= 1'b0;
                        if (pwdata[7:0] == `ARNS_CMD_NMAX) begin
                            if (lba_q) begin
                                sec_q  <= max28[7:0];
                                cyll_q <= max28[15:8];
                                cylh_q <= max28[23:16];
                                head_q <= max28[27:24];
                            end else begin
                                sec_q  <= native_max_sector;
                                cyll_q <= native_max_cyl[7:0];
                                cylh_q <= native_max_cyl[15:8];
                                head_q <= native_max_head;
                            end
                        end else if (pwdata[7:0] == `ARNS_CMD_NMAX_EXT) begin
                            sec_q   <= native_max_lba[7:0];
                            cyll_q  <= native_max_lba[15:8];
                            cylh_q  <= native_max_lba[23:16];
                            hsec_q  <= native_max_lba[31:24];
                            hcyll_q <= native_max_lba[39:32];
                            hcylh_q <= native_max_lba[47:40];
                        end else if (pwdata[7:1] == CMD_READ[7:1]) begin
                            if (rem_q[7:0] == 8'h00) begin
                                rem_q <= `ARNS_FULL_COUNT;
                            end
                            if (lba_q && cur_lba > max28) begin
                                err_q[`ARNS_ERR_IDNF] <= 1'b1;
                                errst_q <= 1'b1;
                            end else begin
                                state_q <= ST_REQ;
                            end
                        end else begin
                            err_q[`ARNS_ERR_ABRT] <= 1'b1;
                            errst_q <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            case (state_q)
                ST_REQ: begin
                    wptr_q  <= {WPS_LOG2{1'b0}};
                    state_q <= ST_FILL;
                end
                ST_FILL: begin
                    if (media_uncorr) begin
                        // failing sector stays in the address registers, uncounted
                        err_q[`ARNS_ERR_UNC] <= 1'b1;
                        errst_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (fill_beat) begin
                        wptr_q <= wptr_q + 1'b1;
                        if (wptr_q == LAST_WORD) begin
                            state_q <= ST_XFER;
                        end
                    end
                end
                ST_XFER: begin
                    if (pop && rptr_q == LAST_WORD) begin
                        rem_q <= rem_q - 1'b1;
                        if (rem_q == 9'h001) begin
                            // address is not advanced past the final sector
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_REQ;
                            if (lba_q) begin
                                {head_q, cylh_q, cyll_q, sec_q} <= cur_lba + 28'h0000001;
                            end else if (sec_q >= geo_sectors) begin
                                sec_q <= 8'h01;
                                if (head_q >= geo_heads - 4'h1) begin
                                    head_q <= 4'h0;
                                    {cylh_q, cyll_q} <= {cylh_q, cyll_q} + 16'h0001;
                                end else begin
                                    head_q <= head_q + 4'h1;
                                end
                            end else begin
                                sec_q <= sec_q + 8'h01;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule // arns_cmd

// >>> testbench/arns_cmd_properties.sv
// port-level checks for the command block
`timescale 1ns/10ps
module arns_cmd_properties #(
    parameter WPS_LOG2 = 8
) (
    input wire        ref_clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire [7:0]  paddr,
    input wire        pslverr,
    input wire        media_req,
    input wire [27:0] media_addr,
    input wire        media_valid,
    input wire        media_ready,
    input wire        media_uncorr
);
    localparam [9:0] WORDS = 10'h001 << WPS_LOG2;
    reg [9:0] beats_q;
    reg       unc_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a sector cut short by an uncorrectable error is exempt from the word count
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            beats_q <= 10'h000;
            unc_q   <= 1'b0;
        end else begin
            beats_q <= media_req ? 10'h000 : beats_q + {9'h000, media_valid && media_ready};
            unc_q   <= !media_req && (unc_q || media_uncorr);
        end
    end
    property p_req_pulse; media_req |=> !media_req; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request too long");
    property p_req_fill; media_req |=> media_ready; endproperty
    a_req_fill: assert property (p_req_fill) else $error("no fill after request");
    property p_fill_cause; $rose(media_ready) |-> $past(media_req); endproperty
    a_fill_cause: assert property (p_fill_cause) else $error("fill without request");
    property p_addr_hold; media_ready |-> $stable(media_addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in fill");
    property p_err_map; psel && penable |-> pslverr == (paddr > 8'h20 || paddr[1:0] != 2'b00);
    endproperty
    a_err_map: assert property (p_err_map) else $error("bad slave error");
    property p_err_phase; pslverr |-> psel && penable; endproperty
    a_err_phase: assert property (p_err_phase) else $error("error outside access");
    property p_unc_stop; media_ready && media_uncorr |=> (!media_ready && !media_req) [*4];
    endproperty
    a_unc_stop: assert property (p_unc_stop) else $error("read went on after error");
    property p_fill_words; $fell(media_ready) && !unc_q |-> beats_q == WORDS; endproperty
    a_fill_words: assert property (p_fill_words) else $error("wrong words per sector");
endmodule // arns_cmd_properties

bind arns_cmd arns_cmd_properties #(.WPS_LOG2(WPS_LOG2)) u_props (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .pslverr(pslverr), .media_req(media_req), .media_addr(media_addr),
    .media_valid(media_valid), .media_ready(media_ready), .media_uncorr(media_uncorr)
);

// >>> testbench/arns_media_model.sv
// behavioural media that fills one sector per request
`timescale 1ns/10ps
module arns_media_model #(
    parameter WORDS = 4
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        media_req,
    input  wire [27:0] media_addr,
    input  wire        media_ready,
    output reg         media_valid,
    output reg  [15:0] media_data,
    output reg         media_uncorr,
    input  wire        slow,
    input  wire [27:0] bad_addr
);
    localparam [9:0] LAST = WORDS;
    reg  [9:0]  word_q;
    reg  [27:0] addr_q;
    reg         tick_q;
    wire [9:0]  word_n = (media_valid && media_ready) ? word_q + 10'h001 : word_q;
    // the bad sector fails after its first word, so a partial fill is seen
    wire        fail = media_ready && addr_q == bad_addr && word_n == 10'h001;
    wire        nxt = media_ready && !media_req && !fail && word_n < LAST && (!slow || tick_q);
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_q       <= 10'h000;
            addr_q       <= 28'h0000000;
            tick_q       <= 1'b0;
            media_valid  <= 1'b0;
            media_data   <= 16'h0000;
            media_uncorr <= 1'b0;
        end else begin
            tick_q       <= ~tick_q;
            media_valid  <= nxt;
            // idle data toggles so a stale word is never mistaken for a fresh one
            media_data   <= nxt ? {addr_q[7:0], word_n[7:0]} : ~media_data;
            media_uncorr <= fail;
            addr_q       <= media_req ? media_addr : addr_q;
            word_q       <= media_req ? 10'h000 : (fail ? LAST : word_n);
        end
    end
endmodule // arns_media_model

// >>> testbench/tb_top.sv
// self-checking bench for the native-max and read-sector command block
`timescale 1ns/10ps
`include "arns_defines.vh"
module tb_top;
    reg         ref_clk, rst, psel, penable, pwrite, slow;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rdat;
    reg  [47:0] nmax;
    reg  [27:0] bad_addr;
    reg  [15:0] ncyl;
    reg  [7:0]  nsec, gsecs, dh_mode;
    reg  [3:0]  nhead, gheads;
    wire [31:0] prdata;
    wire        pready, pslverr, media_req, media_valid, media_ready, media_uncorr;
    wire        media_lba_mode;
    wire [27:0] media_addr;
    wire [15:0] media_data;
    integer     miscompares, num_checks;

    arns_cmd #(.WPS_LOG2(2)) uut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .native_max_lba(nmax), .native_max_cyl(ncyl), .native_max_head(nhead),
        .native_max_sector(nsec), .geo_heads(gheads), .geo_sectors(gsecs),
        .media_req(media_req), .media_lba_mode(media_lba_mode), .media_addr(media_addr),
        .media_valid(media_valid), .media_data(media_data), .media_ready(media_ready),
        .media_uncorr(media_uncorr));
    arns_media_model #(.WORDS(4)) u_media (
        .ref_clk(ref_clk), .rst(rst), .media_req(media_req), .media_addr(media_addr),
        .media_ready(media_ready), .media_valid(media_valid), .media_data(media_data),
        .media_uncorr(media_uncorr), .slow(slow), .bad_addr(bad_addr));

    always #5 ref_clk = ~ref_clk;

    task chk(input [15:0] got, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task apb(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= {24'h000000, d};
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1) @(posedge ref_clk);
            rdat = prdata;
            chk({15'h0000, pslverr}, {15'h0000, a > 8'h20 || a[1:0] != 2'b00});
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rd8(input [7:0] a, input [7:0] e);
        begin
            apb(1'b0, a, 8'h00);
            chk({8'h00, rdat[7:0]}, {8'h00, e});
        end
    endtask

    task wst(input [7:0] v);
        integer n;
        begin
            n = 0;
            apb(1'b0, `ARNS_OFF_CMDSTAT, 8'h00);
            while ((rdat[7:0] & 8'h88) !== v && n < 400) begin
                apb(1'b0, `ARNS_OFF_CMDSTAT, 8'h00);
                n = n + 1;
            end
            chk({8'h00, rdat[7:0] & 8'h88}, {8'h00, v});
        end
    endtask

    task nm(input [7:0] cmd, input [7:0] dh, input [7:0] high_order_byte_select, input [31:0] e);
        begin
            apb(1'b1, `ARNS_OFF_DEVHD, dh);
            apb(1'b1, `ARNS_OFF_CMDSTAT, cmd);
            apb(1'b1, `ARNS_OFF_DEVCTL, high_order_byte_select);
            rd8(`ARNS_OFF_SNUM, e[7:0]);
            rd8(`ARNS_OFF_CYLL, e[15:8]);
            rd8(`ARNS_OFF_CYLH, e[23:16]);
            apb(1'b0, `ARNS_OFF_DEVHD, 8'h00);
            if (cmd == `ARNS_CMD_NMAX) chk({12'h000, rdat[3:0]}, {8'h00, e[31:24]});
            $display("native max test done at %0t", $time);
        end
    endtask

    // chs stepping wraps the sector to 1, then carries into head and cylinder
    function [27:0] next_sec(input [27:0] a);
        begin
            if (dh_mode[`ARNS_DH_LBA] || a[7:0] < gsecs)
                next_sec = a + 28'h0000001;
            else if (a[27:24] >= gheads - 4'h1)
                next_sec = {4'h0, a[23:8] + 16'h0001, 8'h01};
            else
                next_sec = {a[27:24] + 4'h1, a[23:8], 8'h01};
        end
    endfunction

    task run_rd(input [27:0] lba, input [7:0] cnt, input [7:0] cmd, input integer nsec);
        integer s, w;
        reg [27:0] ea;
        begin
            ea = lba;
            apb(1'b1, `ARNS_OFF_DEVCTL, 8'h00);
            apb(1'b1, `ARNS_OFF_SCNT, cnt);
            apb(1'b1, `ARNS_OFF_SNUM, lba[7:0]);
            apb(1'b1, `ARNS_OFF_CYLL, lba[15:8]);
            apb(1'b1, `ARNS_OFF_CYLH, lba[23:16]);
            apb(1'b1, `ARNS_OFF_DEVHD, dh_mode | {4'h0, lba[27:24]});
            apb(1'b1, `ARNS_OFF_CMDSTAT, cmd);
            chk({15'h0000, media_lba_mode}, {15'h0000, dh_mode[`ARNS_DH_LBA]});
            for (s = 0; s < nsec; s = s + 1) begin
                wst(8'h08);
                for (w = 0; w < 4; w = w + 1) begin
                    apb(1'b0, `ARNS_OFF_DATA, 8'h00);
                    chk(rdat[15:0], {ea[7:0], w[7:0]});
                end
                ea = next_sec(ea);
            end
            wst(8'h00);
        end
    endtask

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    initial begin
        #500000;
        miscompares = miscompares + 1;
        $display("MISMATCH at %0t: watchdog expired", $time);
        finish_test;
    end

    initial begin
        {ref_clk, psel, penable, pwrite, slow, paddr, pwdata, rdat} = 0;
        rst = 1'b1;
        nmax = 48'h00000a5b3c7d;
        bad_addr = 28'hfffffff;
        ncyl = 16'h1234;
        nhead = 4'h9;
        nsec = 8'h3f;
        gheads = 4'h4;
        gsecs = 8'h3f;
        dh_mode = 8'he0;
        miscompares = 0;
        num_checks = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd8(`ARNS_OFF_CMDSTAT, 8'h50);
        rd8(`ARNS_OFF_DATA, 8'h00);
        apb(1'b0, 8'h24, 8'h00);
        apb(1'b0, 8'h06, 8'h00);
        nm(`ARNS_CMD_NMAX, 8'he0, 8'h00, 32'h0a5b3c7d);
        nmax = 48'h123456789abc;
        nm(`ARNS_CMD_NMAX, 8'he0, 8'h00, 32'h0fffffff);
        nm(`ARNS_CMD_NMAX, 8'ha0, 8'h00, 32'h0912343f);
        nm(`ARNS_CMD_NMAX_EXT, 8'he0, 8'h00, 32'h00789abc);
        nm(`ARNS_CMD_NMAX_EXT, 8'he0, 8'h80, 32'h00123456);
        nmax = 48'h00000000ffff;
        slow = 1'b1;
        run_rd(28'h00000ff, 8'h02, 8'h21, 2);
        rd8(`ARNS_OFF_SCNT, 8'h00);
        rd8(`ARNS_OFF_SNUM, 8'h00);
        rd8(`ARNS_OFF_CYLL, 8'h01);
        $display("two-sector read done at %0t", $time);
        slow = 1'b0;
        run_rd(28'h0000200, 8'h00, 8'h20, 256);
        rd8(`ARNS_OFF_SCNT, 8'h00);
        rd8(`ARNS_OFF_SNUM, 8'hff);
        rd8(`ARNS_OFF_CYLL, 8'h02);
        $display("full-count read done at %0t", $time);
        dh_mode = 8'ha0;
        run_rd(28'h300053f, 8'h02, 8'h20, 2);
        rd8(`ARNS_OFF_SCNT, 8'h00);
        rd8(`ARNS_OFF_SNUM, 8'h01);
        rd8(`ARNS_OFF_CYLL, 8'h06);
        rd8(`ARNS_OFF_CYLH, 8'h00);
        rd8(`ARNS_OFF_DEVHD, 8'ha0);
        dh_mode = 8'he0;
        $display("chs read done at %0t", $time);
        slow = 1'b1;
        bad_addr = 28'h0000012;
        run_rd(28'h0000011, 8'h03, 8'h20, 1);
        rd8(`ARNS_OFF_SCNT, 8'h02);
        rd8(`ARNS_OFF_SNUM, 8'h12);
        rd8(`ARNS_OFF_ERR, 8'h40);
        rd8(`ARNS_OFF_CMDSTAT, 8'h51);
        run_rd(28'h0010000, 8'h01, 8'h20, 0);
        rd8(`ARNS_OFF_ERR, 8'h10);
        apb(1'b1, `ARNS_OFF_CMDSTAT, 8'h00);
        rd8(`ARNS_OFF_ERR, 8'h04);
        rd8(`ARNS_OFF_CMDSTAT, 8'h51);
        $display("error tests done at %0t", $time);
        finish_test;
    end
endmodule // tb_top
